// ### design/wcu_pkg.sv
// Shared constants for the watchpoint compare unit.
// Assumes a 32-bit AXI4-Lite register bus and one core clock.
package wcu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_W0_ADDR_VAL = 5'h08;
  localparam logic [4:0] IDX_W0_ADDR_MSK = 5'h09;
  localparam logic [4:0] IDX_W0_DATA_VAL = 5'h0a;
  localparam logic [4:0] IDX_W0_DATA_MSK = 5'h0b;
  localparam logic [4:0] IDX_W0_CTL_VAL = 5'h0c;
  localparam logic [4:0] IDX_W0_CTL_MSK = 5'h0d;
  localparam logic [4:0] IDX_W1_ADDR_VAL = 5'h10;
  localparam logic [4:0] IDX_W1_ADDR_MSK = 5'h11;
  localparam logic [4:0] IDX_W1_DATA_VAL = 5'h12;
  localparam logic [4:0] IDX_W1_DATA_IGNORE = 5'h13;
  localparam logic [4:0] IDX_W1_CONTROL_COMPARE = 5'h14;
  localparam logic [4:0] IDX_W1_CONTROL_IGNORE = 5'h15;

  // Register slot inside one watchpoint (index bits 2:0)
  localparam logic [2:0] SUB_ADDR_VAL = 3'h0;
  localparam logic [2:0] SUB_ADDR_MSK = 3'h1;
  localparam logic [2:0] SUB_DATA_VAL = 3'h2;
  localparam logic [2:0] SUB_DATA_MSK = 3'h3;
  localparam logic [2:0] SUB_CTL_VAL = 3'h4;
  localparam logic [2:0] SUB_CTL_MSK = 3'h5;

  // Control field positions
  localparam int CTL_DIR = 0;
  localparam int CTL_SIZE_LO = 1;
  localparam int CTL_SIZE_HI = 2;
  localparam int CTL_COMPRESSED_STATE_CMP = 1;
  localparam int CTL_SEL = 3;
  localparam int CTL_PRIV = 4;
  localparam int CTL_EXT = 5;
  localparam int CTL_CHAIN = 6;
  localparam int CTL_RANGE = 7;
  localparam int CTL_EN = 8;

  // Values after reset
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [8:0] CTL_VAL_RST = 9'h000;
  localparam logic [7:0] CTL_MSK_RST = 8'h00;

  // Bus answers and synchroniser depth
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYNC_STAGES = 3;

  // Channel state of the register bus slave
  typedef enum logic {
    WCU_IDLE = 1'b0,
    WCU_BUSY = 1'b1
  } wcu_bus_e;

endpackage

// ### design/wcu_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to i_clk; output moves once stages 2 and 3 agree.
`timescale 1ns/1ps
module wcu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Data
  input wire logic [W-1:0] i_async,
  input wire logic [W-1:0] i_rst_val,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  logic [W-1:0] st2;
  logic [W-1:0] st3;
  logic [W-1:0] held;
  logic [W-1:0] next_held;

  // Per bit: follow only when the two settled stages agree
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      assign next_held[b] = (st2[b] == st3[b]) ? st3[b] : held[b];
    end
  endgenerate

  // Chain of stages; meta is read by st2 alone
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      st2 <= '0;
      st3 <= '0;
      held <= '0;
    end else if (i_ce) begin
      meta <= i_async;
      st2 <= meta;
      st3 <= st2;
      held <= next_held;
    end
  end

  // Reset value shown until the chain has filled once
  logic [wcu_pkg::SYNC_STAGES:0] fill;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fill <= '0;
    end else if (i_ce) begin
      fill <= {fill[wcu_pkg::SYNC_STAGES-1:0], 1'b1};
    end
  end

  assign o_sync = fill[wcu_pkg::SYNC_STAGES] ? held : i_rst_val;
endmodule

// ### design/wcu_cmp.sv
// One watchpoint comparator: masked address, data and control compare.
// Assumes core buses are on the same clock; purely combinational.
`timescale 1ns/1ps
module wcu_cmp (
  // Programmed value and mask
  input wire logic [31:0] i_addr_val,
  input wire logic [31:0] i_addr_msk,
  input wire logic [31:0] i_data_val,
  input wire logic [31:0] i_data_msk,
  input wire logic [8:0] i_ctl_val,
  input wire logic [7:0] i_ctl_msk,
  // Instruction side
  input wire logic [31:0] i_instr_addr,
  input wire logic [31:0] i_instr_data,
  input wire logic i_compressed_state_cmp,
  input wire logic i_fetch_privilege_cmp,
  // Data side
  input wire logic [31:0] i_data_addr,
  input wire logic [31:0] i_data_bus,
  input wire logic i_data_direction_cmp,
  input wire logic [1:0] i_data_size_cmp,
  input wire logic i_data_privilege_cmp,
  // Link and external conditions
  input wire logic i_ext,
  input wire logic i_chain,
  input wire logic i_range,
  // Results
  output logic o_ac_match,
  output logic o_data_match,
  output logic o_match
);
  wire sel = i_ctl_val[wcu_pkg::CTL_SEL];
  wire [31:0] obs_addr = sel ? i_data_addr : i_instr_addr;
  wire [31:0] obs_data = sel ? i_data_bus : i_instr_data;
  wire [7:0] obs_ctl;
  // Unused instruction bits mirror the value so they never block a match
  assign obs_ctl[wcu_pkg::CTL_DIR] = sel ? i_data_direction_cmp : i_ctl_val[0];
  assign obs_ctl[wcu_pkg::CTL_SIZE_HI] = sel ? i_data_size_cmp[1] : i_ctl_val[2];
  assign obs_ctl[wcu_pkg::CTL_COMPRESSED_STATE_CMP] = sel ? i_data_size_cmp[0] : i_compressed_state_cmp;
  assign obs_ctl[wcu_pkg::CTL_SEL] = sel;
  assign obs_ctl[wcu_pkg::CTL_PRIV] = sel ? i_data_privilege_cmp : i_fetch_privilege_cmp;
  assign obs_ctl[wcu_pkg::CTL_EXT] = i_ext;
  assign obs_ctl[wcu_pkg::CTL_CHAIN] = i_chain;
  assign obs_ctl[wcu_pkg::CTL_RANGE] = i_range;
  // Select bit can never be masked
  wire [7:0] eff_msk = i_ctl_msk & ~(8'h01 << wcu_pkg::CTL_SEL);
  wire addr_ok = &(~(obs_addr ^ i_addr_val) | i_addr_msk);
  wire ctl_ok = &(~(obs_ctl ^ i_ctl_val[7:0]) | eff_msk);
  assign o_ac_match = addr_ok & ctl_ok;
  assign o_data_match = &(~(obs_data ^ i_data_val) | i_data_msk);
  assign o_match = o_ac_match & o_data_match;
endmodule

// ### design/wcu_top.sv
// Watchpoint compare unit: two comparators, chain latch, range link,
// register file over AXI4-Lite and registered break flags to the core.
// Assumes core buses share i_clk; conditions and test reset come from pins.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module wcu_top #(
  parameter int NUM_WP = 2
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Test reset and external conditions from pins
  input wire logic i_trst_n,
  input wire logic i_external_condition_wp0,
  input wire logic i_external_condition_wp1,
  // Instruction side of the core
  input wire logic [31:0] i_instr_addr,
  input wire logic [31:0] i_instr_data,
  input wire logic i_compressed_state_cmp,
  input wire logic i_fetch_privilege_cmp,
  // Data side of the core
  input wire logic [31:0] i_data_addr,
  input wire logic [31:0] i_data_bus,
  input wire logic i_data_direction_cmp,
  input wire logic [1:0] i_data_size_cmp,
  input wire logic i_data_privilege_cmp,
  // Break flags and link observation
  output logic o_instr_break_flag,
  output logic o_data_break_flag,
  output logic o_link_latch_out,
  output logic o_span_out,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        res[k*8 +: 8] = new_w[k*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pin inputs: test reset and both external conditions
  logic [2:0] pins_sync;

  // Three stages, agreement filter
  wcu_sync #(
    .W(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_async({i_trst_n, i_external_condition_wp1, i_external_condition_wp0}),
    .i_rst_val(3'b100),
    .o_sync(pins_sync)
  );
  wire trst_n_s = pins_sync[2];
  wire [1:0] ext_s = pins_sync[1:0];

  // ---- Write channel: address and data taken in either order ----
  // One write in flight at a time
  wcu_pkg::wcu_bus_e wr_state;
  logic aw_held;
  logic w_held;
  logic [4:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Ready only while the slot is free; frozen with the clock enable
  assign s_axi_awready = i_ce & ~aw_held & (wr_state == wcu_pkg::WCU_IDLE);
  assign s_axi_wready = i_ce & ~w_held & (wr_state == wcu_pkg::WCU_IDLE);

  // Answer waits for bready
  assign s_axi_bvalid = (wr_state == wcu_pkg::WCU_BUSY);

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = i_ce & aw_held & w_held & (wr_state == wcu_pkg::WCU_IDLE);

  // Decode of the held write index
  wire wr_unit = aw_idx[4];
  wire [2:0] wr_sub = aw_idx[2:0];

  // Only unit windows map
  wire wr_hit = (aw_idx[4] ^ aw_idx[3]) & (wr_sub <= wcu_pkg::SUB_CTL_MSK);
  wire wr_do = wr_go & wr_hit;

  // Write channel sequencing
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_state <= wcu_pkg::WCU_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 5'h00;
      w_data <= wcu_pkg::WORD_RST;
      w_strb <= 4'h0;
      s_axi_bresp <= wcu_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[6:2];
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        wr_state <= wcu_pkg::WCU_BUSY;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bresp <= wr_hit ? wcu_pkg::RESP_OKAY : wcu_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        wr_state <= wcu_pkg::WCU_IDLE;
      end
    end
  end

  // ---- Watchpoint register file, one set per unit ----
  logic [31:0] addr_val [NUM_WP];
  logic [31:0] addr_msk [NUM_WP];
  logic [31:0] data_val [NUM_WP];
  logic [31:0] data_msk [NUM_WP];
  logic [8:0] ctl_val [NUM_WP];
  logic [7:0] ctl_msk [NUM_WP];

  // Compare results, link feeds
  logic [NUM_WP-1:0] ac_hit;
  logic [NUM_WP-1:0] data_hit;
  logic [NUM_WP-1:0] wp_hit;
  logic [NUM_WP-1:0] chain_in;
  logic [NUM_WP-1:0] range_in;
  wire [1:0] ext_in = ext_s;
  logic link_latch;

  genvar u;

  // One register set per unit
  generate
    for (u = 0; u < NUM_WP; u++) begin : g_wp
      wire sel_me = wr_do & (wr_unit == 1'(u));
      wire [31:0] nv_ctl = merge({23'h00_0000, ctl_val[u]}, w_data, w_strb);
      wire [31:0] nv_msk = merge({24'h00_0000, ctl_msk[u]}, w_data, w_strb);

      // Stored values; masks keep the same layout as values
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          addr_val[u] <= wcu_pkg::WORD_RST;
          addr_msk[u] <= wcu_pkg::WORD_RST;
          data_val[u] <= wcu_pkg::WORD_RST;
          data_msk[u] <= wcu_pkg::WORD_RST;
          ctl_val[u] <= wcu_pkg::CTL_VAL_RST;
          ctl_msk[u] <= wcu_pkg::CTL_MSK_RST;
        end else if (i_ce && sel_me) begin
          case (wr_sub)
            wcu_pkg::SUB_ADDR_VAL: addr_val[u] <= merge(addr_val[u], w_data, w_strb);
            wcu_pkg::SUB_ADDR_MSK: addr_msk[u] <= merge(addr_msk[u], w_data, w_strb);
            wcu_pkg::SUB_DATA_VAL: data_val[u] <= merge(data_val[u], w_data, w_strb);
            wcu_pkg::SUB_DATA_MSK: data_msk[u] <= merge(data_msk[u], w_data, w_strb);
            wcu_pkg::SUB_CTL_VAL: ctl_val[u] <= nv_ctl[8:0];
            wcu_pkg::SUB_CTL_MSK: begin
              ctl_msk[u] <= nv_msk[7:0] & ~(8'h01 << wcu_pkg::CTL_SEL);
            end
            default: ctl_msk[u] <= ctl_msk[u];
          endcase
        end
      end

      // Both buses in; bit 3 picks
      wcu_cmp u_cmp (
        .i_addr_val(addr_val[u]),
        .i_addr_msk(addr_msk[u]),
        .i_data_val(data_val[u]),
        .i_data_msk(data_msk[u]),
        .i_ctl_val(ctl_val[u]),
        .i_ctl_msk(ctl_msk[u]),
        .i_instr_addr(i_instr_addr),
        .i_instr_data(i_instr_data),
        .i_compressed_state_cmp(i_compressed_state_cmp),
        .i_fetch_privilege_cmp(i_fetch_privilege_cmp),
        .i_data_addr(i_data_addr),
        .i_data_bus(i_data_bus),
        .i_data_direction_cmp(i_data_direction_cmp),
        .i_data_size_cmp(i_data_size_cmp),
        .i_data_privilege_cmp(i_data_privilege_cmp),
        .i_ext(ext_in[u]),
        .i_chain(chain_in[u]),
        .i_range(range_in[u]),
        .o_ac_match(ac_hit[u]),
        .o_data_match(data_hit[u]),
        .o_match(wp_hit[u])
      );
    end
  endgenerate

  // Link from unit 1 into unit 0; unit 1 sees no partner, so zero
  assign chain_in = {1'b0, link_latch};
  assign range_in = {1'b0, wp_hit[1]};

  // Chain latch; a wp1 control value write or test reset takes priority
  wire ctl1_write = wr_do & wr_unit & (wr_sub == wcu_pkg::SUB_CTL_VAL);

  // Loads the wp1 data match only on a wp1 address/control hit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_latch <= 1'b0;
    end else if (i_ce) begin
      if (ctl1_write || !trst_n_s) begin
        link_latch <= 1'b0;
      end else if (ac_hit[1]) begin
        link_latch <= data_hit[1];
      end
    end
  end

  // Break requests: enable gates, select bit steers the flag
  logic [NUM_WP-1:0] brk_i;
  logic [NUM_WP-1:0] brk_d;

  // Gate and steer per unit
  generate
    for (u = 0; u < NUM_WP; u++) begin : g_brk
      wire armed = wp_hit[u] & ctl_val[u][wcu_pkg::CTL_EN];
      assign brk_d[u] = armed & ctl_val[u][wcu_pkg::CTL_SEL];
      assign brk_i[u] = armed & ~ctl_val[u][wcu_pkg::CTL_SEL];
    end
  endgenerate

  // Either unit may break
  wire next_instr_break = |brk_i;
  wire next_data_break = |brk_d;

  // Registered flags to the core, one cycle after the bus sample
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_instr_break_flag <= 1'b0;
      o_data_break_flag <= 1'b0;
      o_span_out <= 1'b0;
    end else if (i_ce) begin
      o_instr_break_flag <= next_instr_break;
      o_data_break_flag <= next_data_break;
      o_span_out <= wp_hit[1];
    end
  end

  // Latch is already a flop
  assign o_link_latch_out = link_latch;

  // ---- Read channel ----
  wcu_pkg::wcu_bus_e rd_state;
  assign s_axi_arready = i_ce & (rd_state == wcu_pkg::WCU_IDLE);
  assign s_axi_rvalid = (rd_state == wcu_pkg::WCU_BUSY);

  // Read decode by index
  wire [4:0] rd_idx = s_axi_araddr[6:2];
  wire rd_unit = rd_idx[4];
  wire [2:0] rd_sub = rd_idx[2:0];

  // Same map as writes
  wire rd_hit = (rd_idx[4] ^ rd_idx[3]) & (rd_sub <= wcu_pkg::SUB_CTL_MSK);

  // Misses select zero
  logic [31:0] rd_word;
  always_comb begin
    case (rd_sub)
      wcu_pkg::SUB_ADDR_VAL: rd_word = addr_val[rd_unit];
      wcu_pkg::SUB_ADDR_MSK: rd_word = addr_msk[rd_unit];
      wcu_pkg::SUB_DATA_VAL: rd_word = data_val[rd_unit];
      wcu_pkg::SUB_DATA_MSK: rd_word = data_msk[rd_unit];
      wcu_pkg::SUB_CTL_VAL: rd_word = {23'h00_0000, ctl_val[rd_unit]};
      wcu_pkg::SUB_CTL_MSK: rd_word = {24'h00_0000, ctl_msk[rd_unit]};
      default: rd_word = wcu_pkg::WORD_RST;
    endcase
  end

  // Answer one cycle after the address; unmapped reads zero with an error
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_state <= wcu_pkg::WCU_IDLE;
      s_axi_rdata <= wcu_pkg::WORD_RST;
      s_axi_rresp <= wcu_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_state <= wcu_pkg::WCU_BUSY;
        s_axi_rdata <= rd_hit ? rd_word : wcu_pkg::WORD_RST;
        s_axi_rresp <= rd_hit ? wcu_pkg::RESP_OKAY : wcu_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        rd_state <= wcu_pkg::WCU_IDLE;
      end
    end
  end

  // Protection attributes carry no meaning here
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_awaddr[31:7], s_axi_awaddr[1:0],
                       s_axi_araddr[31:7], s_axi_araddr[1:0]};
endmodule

// ### sim/wcu_top_properties.sv
// Port checker for the watchpoint compare unit.
// Assumes one clock domain; bound onto every wcu_top instance.
`timescale 1ns/1ps
module wcu_top_checker (
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_trst_n,
  // Register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side results
  input wire logic o_instr_break_flag,
  input wire logic o_data_break_flag,
  input wire logic o_link_latch_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [31:0] last_aw;
  logic any_wr;
  // Last write address and whether any write finished
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_aw <= 32'h0000_0000;
      any_wr <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        last_aw <= s_axi_awaddr;
      end
      if (s_axi_bvalid) begin
        any_wr <= 1'b1;
      end
    end
  end
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ctl1_written;
    $rose(s_axi_bvalid) && last_aw == 32'h0000_0050 && s_axi_bresp == wcu_pkg::RESP_OKAY;
  endsequence
  AST_WR_LAT: assert property (s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_EN_GATE: assert property (!any_wr |-> !o_instr_break_flag && !o_data_break_flag)
    else $error("break flag with nothing enabled");
  AST_LINK_WR_CLR: assert property (s_ctl1_written |-> ##[0:1] !o_link_latch_out)
    else $error("link latch kept after control write");
  AST_LINK_TRST: assert property (!i_trst_n [*8] |-> !o_link_latch_out)
    else $error("link latch kept in test reset");
endmodule

bind wcu_top wcu_top_checker u_chk (.i_clk, .i_arst_n, .i_trst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .o_instr_break_flag, .o_data_break_flag, .o_link_latch_out);

// ### sim/wcu_core_model.sv
// Core bus model: drives one side with a commanded transfer per cycle.
// Assumes commands change just after a rising edge of i_clk.
`timescale 1ns/1ps
module wcu_core_model (
  // Clock and command
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_dsel,
  input wire logic [31:0] i_a,
  input wire logic [31:0] i_d,
  input wire logic [3:0] i_c,
  // Core buses
  output logic [31:0] o_ia,
  output logic [31:0] o_id,
  output logic o_it,
  output logic o_ip,
  output logic [31:0] o_da,
  output logic [31:0] o_dd,
  output logic o_dw,
  output logic [1:0] o_ds,
  output logic o_dp
);
  logic [31:0] mv = 32'h0000_0001;
  wire ion = i_go && !i_dsel;
  wire don = i_go && i_dsel;
  // Idle side moves every cycle so no stale value can match by luck
  always @(posedge i_clk) begin
    mv <= {mv[30:0], mv[31] ^ mv[21] ^ mv[1] ^ mv[0]};
    o_ia <= ion ? i_a : mv;
    o_id <= ion ? i_d : ~mv;
    o_it <= ion ? i_c[0] : mv[3];
    o_ip <= ion ? i_c[1] : mv[5];
    o_da <= don ? i_a : ~mv;
    o_dd <= don ? i_d : mv;
    o_dw <= don ? i_c[0] : mv[7];
    o_ds <= don ? i_c[3:2] : mv[9:8];
    o_dp <= don ? i_c[1] : mv[2];
  end
endmodule

// ### sim/wcu_top_tb.sv
// Bench for wcu_top: register bus master, core model and flag checks.
// Assumes package, design, checker and core model compiled first.
`timescale 1ns/1ps
module wcu_top_tb;
  localparam logic [2:0] AV = wcu_pkg::SUB_ADDR_VAL;
  localparam logic [2:0] AM = wcu_pkg::SUB_ADDR_MSK;
  localparam logic [2:0] DV = wcu_pkg::SUB_DATA_VAL;
  localparam logic [2:0] DM = wcu_pkg::SUB_DATA_MSK;
  localparam logic [2:0] CV = wcu_pkg::SUB_CTL_VAL;
  localparam logic [2:0] CM = wcu_pkg::SUB_CTL_MSK;
  localparam logic [1:0] OK = wcu_pkg::RESP_OKAY;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic trst_n = 1'b1;
  logic ext0 = 1'b0;
  logic go = 1'b0;
  logic dsel = 1'b0;
  logic [3:0] cc = 4'h0;
  logic [31:0] ca = 32'h0000_0000;
  logic [31:0] cd = 32'h0000_0000;
  logic [31:0] awaddr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] araddr = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ib, db, lk, sp, it, ip, dw, dp;
  logic [1:0] bresp, rresp, ds;
  logic [31:0] rdata, ia, id, da, dd, rnd, av, dv;
  logic [33:0] exp_q[$];
  int n_mismatch = 0;
  int compares = 0;
  always #2 clk = ~clk;

  wcu_top DUT (.i_clk(clk), .i_arst_n(rst_n), .i_ce(1'b1), .i_trst_n(trst_n),
    .i_external_condition_wp0(ext0), .i_external_condition_wp1(1'b0),
    .i_instr_addr(ia), .i_instr_data(id), .i_compressed_state_cmp(it),
    .i_fetch_privilege_cmp(ip), .i_data_addr(da), .i_data_bus(dd),
    .i_data_direction_cmp(dw), .i_data_size_cmp(ds), .i_data_privilege_cmp(dp),
    .o_instr_break_flag(ib), .o_data_break_flag(db), .o_link_latch_out(lk), .o_span_out(sp),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  wcu_core_model u_core (.i_clk(clk), .i_go(go), .i_dsel(dsel), .i_a(ca), .i_d(cd),
    .i_c(cc), .o_ia(ia), .o_id(id), .o_it(it), .o_ip(ip), .o_da(da), .o_dd(dd),
    .o_dw(dw), .o_ds(ds), .o_dp(dp));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Byte address of a slot: index is {watchpoint code, slot}
  function automatic logic [31:0] ra(input logic w, input logic [2:0] s);
    return {25'h0, w ? 2'h2 : 2'h1, s, 2'h0};
  endfunction
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tmo();
    n_mismatch++;
    report_and_stop();
  endtask
  // Ready is sampled mid-cycle; it only moves on rising edges
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) begin
        chk("bresp", {32'h0, OK}, {32'h0, bresp});
      end
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    if (!tb) begin
      tmo();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int n;
    logic ta, tr;
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    for (n = 0; n < 40 && !tr; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      @(posedge clk);
      if (ta) begin
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    if (!tr) begin
      tmo();
    end
    @(posedge clk);
  endtask
  // One core transfer; e is {instr flag, data flag, link, span}
  task automatic core(input logic s, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] c, input logic [3:0] e);
    go <= 1'b1;
    dsel <= s;
    ca <= a;
    cd <= d;
    cc <= c;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("flags", {30'h0, e}, {30'h0, ib, db, lk, sp});
    @(posedge clk);
  endtask
  // Read results against the oldest note
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("read", exp_q.pop_front(), {rresp, rdata});
    end
  end

  initial begin
    rnd = 32'h0000_0005;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Register shapes, reset values and an unmapped slot
    rd(ra(1'b1, CV), {OK, 32'h0000_0000});
    rd(32'h0000_0000, {wcu_pkg::RESP_SLVERR, 32'h0000_0000});
    wr(ra(1'b1, CM), 32'hFFFF_FFFF);
    rd(ra(1'b1, CM), {OK, 32'h0000_00F7});
    wr(ra(1'b1, CV), 32'hFFFF_FFFF);
    rd(ra(1'b1, CV), {OK, 32'h0000_01FF});
    rnd = nxt(rnd);
    wr(ra(1'b1, DM), rnd);
    rd(ra(1'b1, DM), {OK, rnd});
    wr(ra(1'b1, CV), 32'h0000_0000);
    wr(ra(1'b1, CM), 32'h0000_0000);
    // Instruction side
    av = nxt(rnd);
    dv = nxt(av);
    wr(ra(1'b0, AV), av);
    wr(ra(1'b0, AM), 32'h0000_0010);
    wr(ra(1'b0, DM), 32'hFFFF_FFFF);
    wr(ra(1'b0, CV), 32'h0000_0112);
    core(1'b0, av, dv, 4'h3, 4'h8);
    core(1'b0, av ^ 32'h0000_0010, dv, 4'h3, 4'h8);
    core(1'b0, av ^ 32'h0000_0001, dv, 4'h3, 4'h0);
    core(1'b0, av, dv, 4'h2, 4'h0);
    core(1'b0, av, dv, 4'h1, 4'h0);
    core(1'b1, av, dv, 4'h3, 4'h0);
    wr(ra(1'b0, CM), 32'h0000_0003);
    core(1'b0, av, dv, 4'h2, 4'h8);
    // Data side: direction, size, privilege, data word
    wr(ra(1'b0, CM), 32'h0000_0000);
    wr(ra(1'b0, DM), 32'h0000_0000);
    wr(ra(1'b0, DV), dv);
    wr(ra(1'b0, CV), 32'h0000_011D);
    core(1'b1, av, dv, 4'hB, 4'h4);
    core(1'b1, av, dv, 4'hA, 4'h0);
    core(1'b1, av, dv, 4'h7, 4'h0);
    core(1'b1, av, dv, 4'h9, 4'h0);
    core(1'b1, av, dv ^ 32'h8000_0000, 4'hB, 4'h0);
    core(1'b0, av, dv, 4'hB, 4'h0);
    wr(ra(1'b0, CM), 32'h0000_00FF);
    core(1'b1, av, dv, 4'h0, 4'h4);
    core(1'b0, av, dv, 4'hB, 4'h0);
    wr(ra(1'b0, CV), 32'h0000_001D);
    core(1'b1, av, dv, 4'hB, 4'h0);
    // External condition through its synchroniser
    wr(ra(1'b0, CM), 32'h0000_0000);
    wr(ra(1'b0, CV), 32'h0000_013D);
    core(1'b1, av, dv, 4'hB, 4'h0);
    ext0 <= 1'b1;
    repeat (6) @(posedge clk);
    core(1'b1, av, dv, 4'hB, 4'h4);
    ext0 <= 1'b0;
    // Chain latch, span and both clears
    rnd = nxt(dv);
    wr(ra(1'b1, AV), rnd);
    wr(ra(1'b1, DM), 32'h0000_0000);
    wr(ra(1'b1, DV), dv);
    wr(ra(1'b1, CM), 32'h0000_00F7);
    wr(ra(1'b1, CV), 32'h0000_0008);
    core(1'b1, rnd, dv, 4'h0, 4'h3);
    core(1'b1, rnd, ~dv, 4'h0, 4'h0);
    core(1'b1, rnd, dv, 4'h0, 4'h3);
    wr(ra(1'b0, CV), 32'h0000_015D);
    core(1'b1, av, dv, 4'hB, 4'h6);
    wr(ra(1'b1, CV), 32'h0000_0008);
    core(1'b1, av, dv, 4'hB, 4'h0);
    core(1'b1, rnd, dv, 4'h0, 4'h3);
    wr(ra(1'b0, AM), 32'hFFFF_FFFF);
    wr(ra(1'b0, CV), 32'h0000_01C8);
    core(1'b1, rnd, dv, 4'h0, 4'h7);
    trst_n <= 1'b0;
    repeat (8) @(posedge clk);
    trst_n <= 1'b1;
    core(1'b0, av, dv, 4'h0, 4'h0);
    report_and_stop();
  end
endmodule
